/* File: hw/fsp_sequencer.sv */
/*
 * Self-programming flash sequencer: control, pointer and data registers
 * on Avalon-MM, store-program command window, temporary page buffer,
 * page erase / page write timing with CPU stall, and a byte-wide
 * program-memory load port. Holds the program flash array itself.
 * Assumes the CPU core gives one-cycle store/load strobes synchronous
 * to clk_sys and the EEPROM block gives a write-busy level.
 */
// The address map and register access over Avalon-MM were decided locally.
// Summary of operation
// - Erase runs on code 03 plus store instruction within four cycles.
// - Erase uses only the page field; other pointer and data ignored.
// - CPU is stalled for the whole page erase.
// - Buffer load needs code 01 plus store instruction; data from pair.
// - Loaded word location comes from the word-in-page field.
// - Buffer clears after page write, on clear bit write, on reset.
// - EEPROM write during page loading discards loaded buffer words.
// - Page write needs code 05 plus store instruction; data ignored.
// - CPU is stalled for the whole page write.
// - Address is a 16-bit pointer, high byte and low byte.
// - Low pointer bits pick word in page, high bits pick the page.
// - Program loads are byte addressed; load address bit 0 picks the byte.
// - EEPROM write busy blocks all flash programming commands.
// - Store commands accepted regardless of where code executes.
// - Buffer words may be loaded in any order.
// - Armed command clears itself if no store comes within four cycles.
// - Each erase or write lasts between 3.2 ms and 3.4 ms.
`timescale 1ns/100ps
`default_nettype none

module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int WORD_W      = 3,
    parameter int PAGE_W      = 4,
    parameter int PROG_CYCLES = PROG_DEF_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // CPU core instruction strobes
    input  wire logic        store_program_instr,
    input  wire logic        load_program_instr,
    input  wire logic [15:0] load_addr,
    output logic [7:0]       load_data,
    output logic             load_data_valid,
    output logic             cpu_stall,
    // EEPROM status
    input  wire logic        eeprom_write_busy_bit
);

    localparam int PAGE_WORDS = 2 ** WORD_W;
    localparam int FLASH_W    = PAGE_W + WORD_W;
    localparam int CNT_W      = $clog2(PROG_CYCLES + 1);
    localparam int WIN_W      = $clog2(WINDOW_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYCLES);
    localparam logic [WIN_W-1:0] WIN_LOAD  = WIN_W'(WINDOW_CYCLES);

    initial begin
        if (WORD_W < 1 || PAGE_W < 1 || FLASH_W + 1 > 16) begin
            $error("fsp_sequencer: address fields do not fit the pointer");
        end
        if (PROG_CYCLES < 1) begin
            $error("fsp_sequencer: PROG_CYCLES must be at least one");
        end
    end

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    fsp_avs_req_t req;
    logic         wait_r;
    logic [31:0]  rdata_r;
    logic         wr_go;
    logic [31:0]  rd_nxt;

    fsp_ctrl_t          ctrl_r;
    logic [15:0]        ptr_r;
    logic [15:0]        data_r;
    logic [WIN_W-1:0]   win_r;
    fsp_state_t         state_r;
    logic [CNT_W-1:0]   cnt_r;
    logic [PAGE_W-1:0]  page_r;
    logic [PAGE_WORDS-1:0] valid_r;
    logic               stall_r;

    assign req   = '{avs_address, avs_read, avs_write, avs_writedata,
                     avs_byteenable};
    assign wr_go = req.write && !wait_r;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (req.address)
            OFS_CTRL:   rd_nxt[7:0]  = ctrl_r;
            OFS_PTR:    rd_nxt[15:0] = ptr_r;
            OFS_DATA:   rd_nxt[15:0] = data_r;
            OFS_STATUS: begin
                rd_nxt[BIT_ST_BUSY]   = (state_r != FSP_IDLE);
                rd_nxt[BIT_ST_EEBUSY] = eeprom_write_busy_bit;
                rd_nxt[BIT_ST_WINDOW] = (win_r != '0);
                rd_nxt[BIT_ST_BUFANY] = |valid_r;
            end
            default:    rd_nxt = 32'h0000_0000;
        endcase
    end

    // One wait cycle, then the answer stands for one edge
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            if ((req.read || req.write) && wait_r) begin
                wait_r  <= 1'b0;
                rdata_r <= rd_nxt;
            end else begin
                wait_r  <= 1'b1;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

    // ------------------------------------------------------------------
    // Pointer and data-word registers
    // ------------------------------------------------------------------
    // 16-bit pointer from two bytes
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ptr_r  <= PTR_RESET;
            data_r <= DATA_RESET;
        end else if (wr_go) begin
            for (int b = 0; b < 2; b++) begin
                if (req.byteenable[b] && req.address == OFS_PTR) begin
                    ptr_r[b*8 +: 8] <= req.writedata[b*8 +: 8];
                end
                if (req.byteenable[b] && req.address == OFS_DATA) begin
                    data_r[b*8 +: 8] <= req.writedata[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register and command window
    // ------------------------------------------------------------------
    logic ctrl_wr;
    logic spm_take;
    logic spm_go;
    logic buf_clr_wr;
    logic [WORD_W-1:0] ptr_word;
    logic [PAGE_W-1:0] ptr_page;

    assign ctrl_wr    = wr_go && req.address == OFS_CTRL
                        && req.byteenable[0];
    assign buf_clr_wr = ctrl_wr && req.writedata[BIT_BUF_CLR];
    // No location check on the issuing code
    assign spm_take   = store_program_instr && state_r == FSP_IDLE
                        && win_r != '0;
    assign spm_go     = spm_take && !eeprom_write_busy_bit;

    // Word and page fields of the pointer
    assign ptr_word = ptr_r[WORD_W:1];
    assign ptr_page = ptr_r[FLASH_W:WORD_W+1];

    // Arm bits self-clear after the window
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= CTRL_RESET;
            win_r  <= '0;
        end else if (ctrl_wr && state_r == FSP_IDLE) begin
            // Any code with bit 0 set and bits 7:3 clear arms; any upper bit cancels
            ctrl_r <= (req.writedata[7:3] == 5'h00)
                      ? {5'h00, req.writedata[2:0] & CTRL_CMD_MSK}
                      : CTRL_RESET;
            win_r  <= (req.writedata[7:3] == 5'h00
                       && req.writedata[BIT_ARM]) ? WIN_LOAD : '0;
        end else if (spm_take || win_r == WIN_W'(1)) begin
            ctrl_r <= CTRL_RESET;
            win_r  <= '0;
        end else if (win_r != '0) begin
            win_r  <= win_r - WIN_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: erase and write timing, CPU stall
    // ------------------------------------------------------------------
    logic do_erase;
    logic do_load;
    logic do_write;
    logic prog_done;

    assign do_erase  = spm_go && ctrl_r == CMD_ERASE;
    assign do_load   = spm_go && ctrl_r == CMD_LOAD;
    assign do_write  = spm_go && ctrl_r == CMD_WRITE;
    assign prog_done = state_r != FSP_IDLE && cnt_r == CNT_W'(1);

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= FSP_IDLE;
            cnt_r   <= '0;
            page_r  <= '0;
        end else begin
            unique case (state_r)
                FSP_IDLE: begin
                    if (do_erase || do_write) begin
                        page_r  <= ptr_page;
                        cnt_r   <= PROG_LOAD;
                        state_r <= do_erase ? FSP_ERASE : FSP_WRITE;
                    end
                end
                FSP_ERASE, FSP_WRITE: begin
                    if (prog_done) begin
                        state_r <= FSP_IDLE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r   <= cnt_r - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stall_r <= 1'b0;
        end else if (do_erase || do_write) begin
            stall_r <= 1'b1;
        end else if (prog_done) begin
            stall_r <= 1'b0;
        end
    end

    assign cpu_stall = stall_r;

    // ------------------------------------------------------------------
    // Temporary page buffer
    // ------------------------------------------------------------------
    logic [15:0] buf_mem [PAGE_WORDS];
    logic        load_new;

    assign load_new = do_load && !valid_r[ptr_word];

    // Clear on write done, clear bit, EEPROM write busy or reset
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            valid_r <= '0;
        end else begin
            if ((state_r == FSP_WRITE && prog_done) || buf_clr_wr
                || eeprom_write_busy_bit) begin
                valid_r <= '0;
            end
            if (load_new) begin
                valid_r[ptr_word] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (load_new) begin
            buf_mem[ptr_word] <= data_r;
        end
    end

    // ------------------------------------------------------------------
    // Program flash array
    // ------------------------------------------------------------------
    logic [15:0] flash_mem [2 ** FLASH_W];

    always_ff @(posedge clk_sys) begin
        if (prog_done) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                if (state_r == FSP_ERASE || !valid_r[i]) begin
                    flash_mem[{page_r, WORD_W'(i)}] <= ERASED_WORD;
                end else begin
                    flash_mem[{page_r, WORD_W'(i)}] <= buf_mem[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Program-memory byte load port
    // ------------------------------------------------------------------
    logic [7:0]  ld_data_r;
    logic        ld_valid_r;
    logic [15:0] ld_word;

    assign ld_word = flash_mem[load_addr[FLASH_W:1]];

    // Bit 0 picks low or high byte
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ld_data_r  <= 8'h00;
            ld_valid_r <= 1'b0;
        end else begin
            ld_valid_r <= load_program_instr && state_r == FSP_IDLE;
            if (load_program_instr && state_r == FSP_IDLE) begin
                ld_data_r <= load_addr[0] ? ld_word[15:8] : ld_word[7:0];
            end
        end
    end

    assign load_data       = ld_data_r;
    assign load_data_valid = ld_valid_r;

endmodule

`default_nettype wire

/* File: hw/fsp_pkg.sv */
/*
 * Constants and types shared by the self-programming flash sequencer:
 * register offsets, control field layout, command codes, timing counts.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package fsp_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_PTR    = 4'h4;
    localparam logic [3:0] OFS_DATA   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // ------------------------------------------------------------------
    // Control register fields and command codes
    // ------------------------------------------------------------------
    localparam int BIT_ARM      = 0;
    localparam int BIT_ERASE    = 1;
    localparam int BIT_PG_WRITE = 2;
    localparam int BIT_BUF_CLR  = 4;

    localparam logic [7:0] CMD_ERASE    = 8'h03;
    localparam logic [7:0] CMD_LOAD     = 8'h01;
    localparam logic [7:0] CMD_WRITE    = 8'h05;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [2:0] CTRL_CMD_MSK = 3'h7;

    // Status register bit positions
    localparam int BIT_ST_BUSY   = 0;
    localparam int BIT_ST_EEBUSY = 1;
    localparam int BIT_ST_WINDOW = 2;
    localparam int BIT_ST_BUFANY = 3;

    localparam logic [15:0] PTR_RESET   = 16'h0000;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 20;
    localparam int WINDOW_CYCLES  = 4;
    localparam int PROG_MIN_NS    = 3200000;
    localparam int PROG_MAX_NS    = 3400000;
    localparam int PROG_MIN_CYC   = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_MAX_CYC   = (PROG_MAX_NS * CLK_MHZ) / 1000;
    localparam int PROG_DEF_CYC   = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rsv_hi;
        logic       buf_clr;
        logic       rsv_lo;
        logic       pg_write;
        logic       pg_erase;
        logic       arm;
    } fsp_ctrl_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } fsp_avs_req_t;

    typedef enum logic [2:0] {
        FSP_IDLE  = 3'b001,
        FSP_ERASE = 3'b010,
        FSP_WRITE = 3'b100
    } fsp_state_t;

endpackage

/* File: tb/fsp_monitor.sv */
/* Checker for the flash sequencer: bus answer, command window, stall
   timing and load port. Sees only the top ports; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module fsp_monitor
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_DEF_CYC
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // CPU side
    input wire logic        store_program_instr,
    input wire logic        load_program_instr,
    input wire logic        load_data_valid,
    input wire logic        cpu_stall,
    input wire logic        eeprom_write_busy_bit
);
    logic [2:0] win_r;
    logic [7:0] cmd_r;
    int         cnt_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Window shadow and stall length
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            win_r <= 3'h0;
            cmd_r <= 8'h00;
        end else if (avs_write && !avs_waitrequest
                     && avs_address == OFS_CTRL) begin
            win_r <= avs_writedata[0] ? 3'h4 : 3'h0;
            cmd_r <= avs_writedata[7:0];
        end else if (store_program_instr || win_r == 3'h0) begin
            win_r <= 3'h0;
        end else begin
            win_r <= win_r - 3'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cpu_stall ? cnt_r + 1 : 0;
        end
    end
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long answer");
    property p_stall_cause;
        $rose(cpu_stall) |-> $past(store_program_instr && win_r != 3'h0
            && !eeprom_write_busy_bit
            && (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE));
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("stall without valid command");
    property p_stall_go;
        store_program_instr && win_r != 3'h0 && !eeprom_write_busy_bit
            && (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE) |=> cpu_stall;
    endproperty
    a_stall_go: assert property (p_stall_go)
        else $error("command did not stall");
    property p_ee_block;
        store_program_instr && eeprom_write_busy_bit && !cpu_stall
            |=> !cpu_stall;
    endproperty
    a_ee_block: assert property (p_ee_block)
        else $error("command ran while eeprom busy");
    property p_no_arm;
        store_program_instr && (win_r == 3'h0 || cmd_r == CMD_LOAD)
            && !cpu_stall |=> !cpu_stall;
    endproperty
    a_no_arm: assert property (p_no_arm)
        else $error("stall from unarmed or load store");
    property p_stall_len;
        $fell(cpu_stall) |-> cnt_r == PROG_CYCLES;
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall length wrong");
    property p_stall_max;
        cpu_stall |-> cnt_r < PROG_CYCLES;
    endproperty
    a_stall_max: assert property (p_stall_max)
        else $error("stall too long");
    property p_load_ans;
        load_program_instr && !cpu_stall |=> load_data_valid;
    endproperty
    a_load_ans: assert property (p_load_ans)
        else $error("load not answered");
    property p_load_only;
        load_data_valid |-> $past(load_program_instr);
    endproperty
    a_load_only: assert property (p_load_only)
        else $error("load answer without request");
endmodule
bind fsp_sequencer fsp_monitor #(.PROG_CYCLES(PROG_CYCLES)) fsp_monitor_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .store_program_instr(store_program_instr),
    .load_program_instr(load_program_instr),
    .load_data_valid(load_data_valid), .cpu_stall(cpu_stall),
    .eeprom_write_busy_bit(eeprom_write_busy_bit)
);
`default_nettype wire

/* File: tb/fsp_cpu_model.sv */
/* CPU core model: store-program and byte load strobes.
   Assumes its tasks are called just after a clk_sys edge. */
`timescale 1ns/100ps
`default_nettype none
module fsp_cpu_model (
    // Clock
    input  wire logic        clk_sys,
    // Strobes
    output var  logic        store_program_instr,
    output var  logic        load_program_instr,
    output var  logic [15:0] load_addr,
    // Answer
    input  wire logic [7:0]  load_data,
    input  wire logic        load_data_valid
);
    initial begin
        store_program_instr = 1'b0;
        load_program_instr  = 1'b0;
        load_addr           = 16'h0000;
    end
    // Strobe a set delay into the window
    task automatic store(input int dly);
        repeat (dly) @(posedge clk_sys);
        store_program_instr <= 1'b1;
        @(posedge clk_sys);
        store_program_instr <= 1'b0;
    endtask
    // Address inverted when idle
    task automatic load(input logic [15:0] a, output logic [8:0] r);
        load_program_instr <= 1'b1;
        load_addr          <= a;
        @(posedge clk_sys);
        load_program_instr <= 1'b0;
        load_addr          <= ~a;
        @(posedge clk_sys);
        r = {load_data_valid, load_data};
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/* Self-checking bench for the flash sequencer with a reference model.
   Assumes PROG_CYCLES of 8 and the default page geometry. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fsp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        store_program_instr;
    logic        load_program_instr;
    logic [15:0] load_addr;
    logic [7:0]  load_data;
    logic        load_data_valid;
    logic        cpu_stall;
    logic        ee_busy = 1'b0;
    int          mismatches = 0;
    int          checks = 0;
    int unsigned seed = 49;
    int          fl [128];
    int          bf [8];
    bit          bv [8];
    always #25 clk_sys = ~clk_sys;
    fsp_sequencer #(.PROG_CYCLES(8)) fsp_sequencer_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .store_program_instr(store_program_instr),
        .load_program_instr(load_program_instr), .load_addr(load_addr),
        .load_data(load_data), .load_data_valid(load_data_valid),
        .cpu_stall(cpu_stall), .eeprom_write_busy_bit(ee_busy));
    fsp_cpu_model fsp_cpu_model_inst (
        .clk_sys(clk_sys), .store_program_instr(store_program_instr),
        .load_program_instr(load_program_instr), .load_addr(load_addr),
        .load_data(load_data), .load_data_valid(load_data_valid));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                mismatches++;
                final_report();
            end
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic clr_buf();
        for (int i = 0; i < 8; i++) bv[i] = 0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] p,
                       input logic [15:0] d, input int dly);
        logic [31:0] q;
        int          n;
        int          pg;
        bit          ok;
        bus(1, OFS_PTR, {16'h0, p}, q);
        bus(1, OFS_DATA, {16'h0, d}, q);
        bus(1, OFS_CTRL, {24'h0, c}, q);
        fsp_cpu_model_inst.store(dly);
        pg = p[7:4];
        ok = dly < 4 && !ee_busy
             && (c == CMD_ERASE || c == CMD_LOAD || c == CMD_WRITE);
        if (ok && c == CMD_LOAD && !bv[p[3:1]]) begin
            bf[p[3:1]] = d;
            bv[p[3:1]] = 1;
        end
        for (int i = 0; i < 8; i++) begin
            if (ok && c != CMD_LOAD) begin
                fl[pg*8+i] = (c == CMD_WRITE && bv[i]) ? bf[i] : 'hffff;
                if (c == CMD_WRITE) bv[i] = 0;
            end
        end
        @(posedge clk_sys);
        #1;
        chk("cpu_stall", ok && c != CMD_LOAD, cpu_stall);
        n = 0;
        while (cpu_stall !== 1'b0) begin
            @(posedge clk_sys);
            n++;
            if (n > 40) begin
                mismatches++;
                final_report();
            end
        end
    endtask
    task automatic chk_page(input int pg);
        logic [8:0] r;
        @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            fsp_cpu_model_inst.load(16'(pg * 16 + i), r);
            chk("load", {1'b1, 8'(fl[pg*8+i/2] >> (8*(i%2)))}, r);
        end
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        clr_buf();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [15:0] d;
        int          k;
        do_reset();
        bus(0, OFS_CTRL, 0, q);
        chk("ctrl", {24'h0, CTRL_RESET}, q);
        bus(0, OFS_PTR, 0, q);
        chk("ptr", {16'h0, PTR_RESET}, q);
        bus(1, 4'h2, xs(), q);
        bus(0, 4'h2, 0, q);
        chk("unmapped", 32'h0, q);
        d = 16'(xs());
        bus(1, OFS_DATA, {16'h0, d}, q);
        bus(0, OFS_DATA, 0, q);
        chk("data", {16'h0, d}, q);
        bus(1, OFS_CTRL, {24'h0, CMD_ERASE}, q);
        bus(0, OFS_STATUS, 0, q);
        chk("status", 32'h1 << BIT_ST_WINDOW, q);
        bus(0, OFS_CTRL, 0, q);
        chk("ctrl", {24'h0, CTRL_RESET}, q);
        cmd(CMD_ERASE, 16'h0030 | 16'(xs() & 'hff0f), 16'(xs()), 3);
        cmd(CMD_ERASE, 16'h0050, 16'h0, 4);
        cmd(CMD_ERASE, 16'h0050, 16'h0, 0);
        chk_page(3);
        chk_page(5);
        k = xs() % 8;
        for (int i = 0; i < 8; i++) begin
            cmd(CMD_LOAD, 16'(((i * 5 + k) % 8) * 2), 16'(xs()), i % 4);
        end
        fsp_cpu_model_inst.store(0);
        cmd(8'h07, 16'h0002, 16'h0, 0);
        bus(0, OFS_STATUS, 0, q);
        chk("status", 32'h1 << BIT_ST_BUFANY, q);
        cmd(CMD_WRITE, 16'h0030, 16'(xs()), 1);
        chk_page(3);
        cmd(CMD_LOAD, 16'h0002, 16'(xs()), 0);
        bus(1, OFS_CTRL, 32'h10, q);
        clr_buf();
        cmd(CMD_LOAD, 16'h0006, 16'(xs()), 2);
        cmd(CMD_WRITE, 16'h0050, 16'h0, 0);
        chk_page(5);
        cmd(CMD_LOAD, 16'h0004, 16'(xs()), 0);
        ee_busy <= 1'b1;
        clr_buf();
        cmd(CMD_ERASE, 16'h0030, 16'h0, 0);
        bus(0, OFS_STATUS, 0, q);
        chk("status", 1, q[BIT_ST_EEBUSY]);
        // Busy clear before the next command
        ee_busy <= 1'b0;
        cmd(CMD_LOAD, 16'h000e, 16'(xs()), 3);
        cmd(CMD_WRITE, 16'h0050, 16'h0, 0);
        chk_page(5);
        cmd(8'h13, 16'h0050, 16'h0, 0);
        chk_page(5);
        cmd(CMD_LOAD, 16'h0008, 16'(xs()), 0);
        do_reset();
        cmd(CMD_WRITE, 16'h0030, 16'h0, 0);
        chk_page(3);
        final_report();
    end
endmodule
`default_nettype wire
